/* File: inc/pms_pkg.sv */
// Purpose: constants and types for the power mode sequencer
// Assumes: clk_i at 100 MHz, classic Wishbone with 32-bit data
// Notes: offsets are byte addresses of aligned words
//
// Notes on behaviour
// - exactly four power modes 0..3; 0 fully active, 3 lowest power
// - mode 0: regulator on, fast rc and/or crystal run, one slow oscillator runs
// - mode 1: regulator on, both fast oscillators off, one slow oscillator runs
// - modes 1 and 2 wake to mode 0 on reset, external interrupt or timer expiry
// - mode 2: regulator off, fast oscillators off, one slow oscillator runs
// - mode 3: regulator off and every oscillator stopped
// - mode 3 wakes only on reset, external interrupt or pending interrupt
// - sleep timer counts slow oscillator periods, runs in every mode except 3
// - sleep timer has selectable resolutions trading step against longest timeout
// - sleep timer expiry wakes the system from mode 1 or 2
// - enabled watchdog must be cleared periodically, else the device resets
// - a pending interrupt in modes 1..3 first brings the device to mode 0
// - retained memory half stays powered in modes 2 and 3, other half not
package pms_pkg;

  // ---------------------------------------------------------------
  // clocking and times
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SLOW_HZ       = 32_768;
  localparam int unsigned SLOW_DIV      = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
  localparam logic [11:0] SLOW_DIV_M1   = 12'(SLOW_DIV - 1);
  localparam int unsigned CLK_STOP_NS   = 100;
  localparam int unsigned REG_SETTLE_NS = 2000;
  localparam int unsigned OSC_SETTLE_NS = 1000;
  localparam int unsigned RST_HOLD_NS   = 1000;
  localparam logic [7:0]  CLK_STOP_CYC  = 8'((CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  REG_SET_CYC   = 8'((REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  OSC_SET_CYC   = 8'((OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RST_HOLD_CYC  = 8'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_CMD      = 8'h04;
  localparam logic [7:0] ADR_WDOG     = 8'h08;
  localparam logic [7:0] ADR_ST_CFG   = 8'h0C;
  localparam logic [7:0] ADR_ST_CMP   = 8'h10;
  localparam logic [7:0] ADR_ST_CNT   = 8'h14;
  localparam logic [7:0] ADR_STATUS   = 8'h18;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FAST_LSB = 2;
  localparam int unsigned CTRL_SLOWX    = 4;
  localparam int unsigned CMD_SLEEP     = 0;
  localparam int unsigned WDOG_EN       = 0;
  localparam int unsigned WDOG_CLR      = 1;
  localparam int unsigned IRQ_TIMER     = 0;
  localparam int unsigned IRQ_EXT       = 1;
  localparam int unsigned IRQ_WDOG      = 2;
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [1:0]  RES_RST       = 2'h0;
  localparam logic [23:0] CMP_RST       = 24'h007FFF;
  localparam logic [2:0]  IRQ_RST       = 3'h0;
  localparam logic [1:0]  FAST_RC_ONLY  = 2'h0;
  localparam logic [1:0]  FAST_XO_ONLY  = 2'h1;

  // ---------------------------------------------------------------
  // modes and sequencer states
  // ---------------------------------------------------------------
  localparam logic [1:0] ACTIVE_POWER_MODE   = 2'h0;
  localparam logic [1:0] LIGHT_SLEEP_MODE    = 2'h1;
  localparam logic [1:0] DEEP_SLEEP_MODE     = 2'h2;
  localparam logic [1:0] SHUTDOWN_SLEEP_MODE = 2'h3;

  typedef enum logic [4:0] {
    ST_ACTIVE  = 5'b00001,
    ST_CLKSTOP = 5'b00010,
    ST_SLEEP   = 5'b00100,
    ST_REGUP   = 5'b01000,
    ST_OSCUP   = 5'b10000
  } pms_state_t;

endpackage

/* File: rtl/pms_sync.sv */
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pms_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // two stages, reset to idle pin level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

/* File: rtl/pms_sleep_timer.sv */
// Purpose: sleep timer counting slow oscillator periods
// Assumes: tick_i is a one-cycle pulse per slow period
// Notes: counter wraps at the compare value, pulsing expire_o
`timescale 1ns/1ps
module pms_sleep_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        run_i,
  input  wire logic [1:0]  res_i,
  input  wire logic [23:0] cmp_i,
  output logic      [23:0] count_o,
  output logic             expire_o
);

  logic [5:0]  pre;
  logic [5:0]  next_pre;
  logic [5:0]  lim;
  logic [23:0] next_count;
  logic        next_expire;
  logic        step;

  // resolution sets ticks per count: 1, 4, 16 or 64
  always_comb begin
    lim         = 6'((6'h01 << {res_i, 1'b0}) - 6'h01);
    step        = tick_i & run_i & (pre >= lim);
    next_pre    = pre;
    next_count  = count_o;
    next_expire = 1'b0;
    if (tick_i && run_i) begin
      next_pre = (pre >= lim) ? 6'h00 : 6'(pre + 6'h01); // a finer setting must not strand pre above lim
    end
    if (step) begin
      next_expire = (count_o == cmp_i);
      next_count  = (count_o == cmp_i) ? 24'h000000 : 24'(count_o + 24'h000001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre      <= 6'h00;
      count_o  <= 24'h000000;
      expire_o <= 1'b0;
    end else begin
      pre      <= next_pre;
      count_o  <= next_count;
      expire_o <= next_expire;
    end
  end

  property p_fine_step;
    @(posedge clk_i) disable iff (rst_i)
    tick_i && run_i && res_i == 2'h0 && cmp_i != 24'h000000 |=> count_o != $past(count_o);
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("timer missed a fine step");

endmodule

/* File: rtl/pms_top.sv */
// Purpose: power mode sequencer with sleep timer and watchdog
// Assumes: Wishbone classic slave, pins synchronised here
// Notes: logic lives in the always-on domain
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module pms_top #(
  parameter int unsigned WDOG_TICKS = 32768
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_reset_n_i,
  input  wire logic        ext_irq_i,
  input  wire logic        irq_pending_i,
  output logic             irq_o,
  output logic             sys_reset_o,
  output logic      [1:0]  power_mode_o,
  output logic             core_reg_on_o,
  output logic             core_clk_en_o,
  output logic             fast_rc_oscillator_en_o,
  output logic             crystal_oscillator_en_o,
  output logic             slow_rc_oscillator_en_o,
  output logic             slow_crystal_oscillator_en_o,
  output logic             retained_ram_pwr_o,
  output logic             volatile_ram_pwr_o
);

  // ---------------------------------------------------------------
  // pin synchronisers and slow tick divider
  // ---------------------------------------------------------------
  logic [1:0]  pins_s;
  logic        rst_n_s;
  logic        eirq_s;
  logic [11:0] div_cnt;
  logic [11:0] next_div_cnt;
  logic        slow_tick;
  logic        next_slow_tick;

  pms_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ext_irq_i, ext_reset_n_i}),
    .q_o   (pins_s)
  );

  assign rst_n_s = pins_s[0];
  assign eirq_s  = pins_s[1];

  // slow oscillator period as a one-cycle enable
  always_comb begin
    next_div_cnt   = 12'(div_cnt + 12'h001);
    next_slow_tick = 1'b0;
    if (div_cnt == pms_pkg::SLOW_DIV_M1) begin
      next_div_cnt   = 12'h000;
      next_slow_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt   <= 12'h000;
      slow_tick <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      slow_tick <= next_slow_tick;
    end
  end

  // ---------------------------------------------------------------
  // register file on the Wishbone slave
  // ---------------------------------------------------------------
  pms_pkg::pms_state_t state;
  pms_pkg::pms_state_t next_state;
  logic [1:0]  cur_mode;
  logic [4:0]  ctrl;
  logic [4:0]  next_ctrl;
  logic        wd_en;
  logic        next_wd_en;
  logic [1:0]  st_res;
  logic [1:0]  next_st_res;
  logic [23:0] st_cmp;
  logic [23:0] next_st_cmp;
  logic [23:0] st_cnt;
  logic        st_exp;
  logic [2:0]  irq_stat;
  logic [2:0]  next_irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;
  logic [2:0]  irq_set;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_irq;
  logic        sleep_req;
  logic        wd_clr;
  logic        wd_fire;
  logic        wr;
  logic        soft_rst;

  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign soft_rst = ~rst_n_s | wd_fire;
  assign irq_set  = {wd_fire, state == pms_pkg::ST_SLEEP && eirq_s, st_exp};
  assign sleep_req = wr && wb_adr_i == pms_pkg::ADR_CMD && wb_dat_i[pms_pkg::CMD_SLEEP];
  assign wd_clr    = wr && wb_adr_i == pms_pkg::ADR_WDOG && wb_dat_i[pms_pkg::WDOG_CLR];

  // decode, write on the acknowledged edge, read data with the ack
  always_comb begin
    next_ack      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat      = wb_dat_o;
    next_ctrl     = ctrl;
    next_wd_en    = wd_en;
    next_st_res   = st_res;
    next_st_cmp   = st_cmp;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat | irq_set;
    if (wr) begin
      unique case (wb_adr_i)
        pms_pkg::ADR_CTRL:     next_ctrl = wb_dat_i[4:0];
        pms_pkg::ADR_WDOG:     next_wd_en = wd_en | wb_dat_i[pms_pkg::WDOG_EN];
        pms_pkg::ADR_ST_CFG:   next_st_res = wb_dat_i[1:0];
        pms_pkg::ADR_IRQ_MASK: next_irq_mask = wb_dat_i[2:0];
        pms_pkg::ADR_IRQ_STAT: next_irq_stat = (irq_stat & ~wb_dat_i[2:0]) | irq_set;
        default: ;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == pms_pkg::ADR_ST_CMP) begin
      for (int b = 0; b < 3; b++) begin
        if (wb_sel_i[b]) begin
          next_st_cmp[8*b +: 8] = wb_dat_i[8*b +: 8];
        end
      end
    end
    if (soft_rst) begin
      next_ctrl  = pms_pkg::CTRL_RST;
      next_wd_en = 1'b0;
    end
    if (next_ack) begin
      unique case (wb_adr_i)
        pms_pkg::ADR_CTRL:     next_dat = {27'h0, ctrl};
        pms_pkg::ADR_WDOG:     next_dat = {31'h0, wd_en};
        pms_pkg::ADR_ST_CFG:   next_dat = {30'h0, st_res};
        pms_pkg::ADR_ST_CMP:   next_dat = {8'h00, st_cmp};
        pms_pkg::ADR_ST_CNT:   next_dat = {8'h00, st_cnt};
        pms_pkg::ADR_STATUS:   next_dat = {24'h0, state, cur_mode, core_reg_on_o};
        pms_pkg::ADR_IRQ_STAT: next_dat = {29'h0, irq_stat};
        pms_pkg::ADR_IRQ_MASK: next_dat = {29'h0, irq_mask};
        default:               next_dat = 32'h00000000;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl     <= pms_pkg::CTRL_RST;
      wd_en    <= 1'b0;
      st_res   <= pms_pkg::RES_RST;
      st_cmp   <= pms_pkg::CMP_RST;
      irq_stat <= pms_pkg::IRQ_RST;
      irq_mask <= pms_pkg::IRQ_RST;
      irq_o    <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      ctrl     <= next_ctrl;
      wd_en    <= next_wd_en;
      st_res   <= next_st_res;
      st_cmp   <= next_st_cmp;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq_o    <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // sleep timer
  // ---------------------------------------------------------------
  logic st_run;

  assign st_run = !(state == pms_pkg::ST_SLEEP && cur_mode == pms_pkg::SHUTDOWN_SLEEP_MODE);

  pms_sleep_timer u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (slow_tick),
    .run_i    (st_run),
    .res_i    (st_res),
    .cmp_i    (st_cmp),
    .count_o  (st_cnt),
    .expire_o (st_exp)
  );

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  logic [1:0] next_mode;
  logic [7:0] wait_cnt;
  logic [7:0] next_wait;
  logic       wake;
  logic       osc_on;
  logic       slow_on;
  logic       n_reg;
  logic       n_clk;
  logic       n_frc;
  logic       n_xo;
  logic       n_src;
  logic       n_sxo;
  logic [1:0] n_pm;

  // reset, pins and pending interrupts wake every sleep; timer not in mode 3
  assign wake = ~rst_n_s | eirq_s | irq_pending_i
              | (st_exp && cur_mode != pms_pkg::SHUTDOWN_SLEEP_MODE);

  always_comb begin
    next_state = state;
    next_mode  = cur_mode;
    next_wait  = (wait_cnt == 8'h00) ? 8'h00 : 8'(wait_cnt - 8'h01);
    unique case (state)
      pms_pkg::ST_ACTIVE: begin
        if (sleep_req && ctrl[1:0] != pms_pkg::ACTIVE_POWER_MODE) begin
          next_mode  = ctrl[pms_pkg::CTRL_MODE_LSB +: 2];
          next_state = pms_pkg::ST_CLKSTOP;
          next_wait  = 8'(pms_pkg::CLK_STOP_CYC - 8'h01);
        end
      end
      pms_pkg::ST_CLKSTOP: begin
        if (wait_cnt == 8'h00) begin
          next_state = pms_pkg::ST_SLEEP;
        end
      end
      pms_pkg::ST_SLEEP: begin
        if (wake && cur_mode != pms_pkg::LIGHT_SLEEP_MODE) begin
          next_state = pms_pkg::ST_REGUP;
          next_wait  = 8'(pms_pkg::REG_SET_CYC - 8'h01);
        end else if (wake) begin
          next_state = pms_pkg::ST_OSCUP;
          next_wait  = 8'(pms_pkg::OSC_SET_CYC - 8'h01);
        end
      end
      pms_pkg::ST_REGUP: begin
        if (wait_cnt == 8'h00) begin
          next_state = pms_pkg::ST_OSCUP;
          next_wait  = 8'(pms_pkg::OSC_SET_CYC - 8'h01);
        end
      end
      pms_pkg::ST_OSCUP: begin
        if (wait_cnt == 8'h00) begin
          next_state = pms_pkg::ST_ACTIVE;
          next_mode  = pms_pkg::ACTIVE_POWER_MODE;
        end
      end
    endcase
    // supplies and oscillators follow the next state
    osc_on  = next_state == pms_pkg::ST_ACTIVE || next_state == pms_pkg::ST_OSCUP;
    slow_on = !(next_state == pms_pkg::ST_SLEEP && next_mode == pms_pkg::SHUTDOWN_SLEEP_MODE);
    n_reg   = !(next_state == pms_pkg::ST_SLEEP && next_mode[1]);
    n_clk   = next_state == pms_pkg::ST_ACTIVE;
    n_frc   = osc_on && ctrl[pms_pkg::CTRL_FAST_LSB +: 2] != pms_pkg::FAST_XO_ONLY;
    n_xo    = osc_on && ctrl[pms_pkg::CTRL_FAST_LSB +: 2] != pms_pkg::FAST_RC_ONLY;
    n_src   = slow_on && !ctrl[pms_pkg::CTRL_SLOWX];
    n_sxo   = slow_on && ctrl[pms_pkg::CTRL_SLOWX];
    n_pm    = n_clk ? pms_pkg::ACTIVE_POWER_MODE : next_mode;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                        <= pms_pkg::ST_ACTIVE;
      cur_mode                     <= pms_pkg::ACTIVE_POWER_MODE;
      wait_cnt                     <= 8'h00;
      core_reg_on_o                <= 1'b1;
      core_clk_en_o                <= 1'b1;
      fast_rc_oscillator_en_o      <= 1'b1;
      crystal_oscillator_en_o      <= 1'b1;
      slow_rc_oscillator_en_o      <= 1'b1;
      slow_crystal_oscillator_en_o <= 1'b0;
      power_mode_o                 <= pms_pkg::ACTIVE_POWER_MODE;
      retained_ram_pwr_o           <= 1'b1;
      volatile_ram_pwr_o           <= 1'b1;
    end else begin
      state                        <= next_state;
      cur_mode                     <= next_mode;
      wait_cnt                     <= next_wait;
      core_reg_on_o                <= n_reg;
      core_clk_en_o                <= n_clk;
      fast_rc_oscillator_en_o      <= n_frc;
      crystal_oscillator_en_o      <= n_xo;
      slow_rc_oscillator_en_o      <= n_src;
      slow_crystal_oscillator_en_o <= n_sxo;
      power_mode_o                 <= n_pm;
      retained_ram_pwr_o           <= 1'b1;
      volatile_ram_pwr_o           <= n_reg;
    end
  end

  // ---------------------------------------------------------------
  // watchdog and system reset
  // ---------------------------------------------------------------
  logic [15:0] wd_cnt;
  logic [15:0] next_wd_cnt;
  logic        next_fire;
  logic [7:0]  hold;
  logic [7:0]  next_hold;
  logic        next_sys_rst;

  // counts slow periods while active; a clear restarts it
  always_comb begin
    next_wd_cnt = wd_cnt;
    next_fire   = 1'b0;
    next_hold   = (hold == 8'h00) ? 8'h00 : 8'(hold - 8'h01);
    if (!wd_en || wd_clr) begin
      next_wd_cnt = 16'h0000;
    end else if (slow_tick && state == pms_pkg::ST_ACTIVE) begin
      if (wd_cnt == 16'(WDOG_TICKS - 1)) begin
        next_fire   = 1'b1;
        next_wd_cnt = 16'h0000;
      end else begin
        next_wd_cnt = 16'(wd_cnt + 16'h0001);
      end
    end
    if (next_fire) begin
      next_hold = 8'(pms_pkg::RST_HOLD_CYC - 8'h01);
    end
    next_sys_rst = ~rst_n_s | next_fire | (next_hold != 8'h00);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt      <= 16'h0000;
      wd_fire     <= 1'b0;
      hold        <= 8'h00;
      sys_reset_o <= 1'b1;
    end else begin
      wd_cnt      <= next_wd_cnt;
      wd_fire     <= next_fire;
      hold        <= next_hold;
      sys_reset_o <= next_sys_rst;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_active_pm;
    state == pms_pkg::ST_ACTIVE |-> power_mode_o == pms_pkg::ACTIVE_POWER_MODE && core_clk_en_o;
  endproperty
  a_active_pm: assert property (p_active_pm) else $error("active state not mode 0");

  property p_mode0_osc;
    state == pms_pkg::ST_ACTIVE |-> core_reg_on_o && (fast_rc_oscillator_en_o || crystal_oscillator_en_o)
      && (slow_rc_oscillator_en_o ^ slow_crystal_oscillator_en_o);
  endproperty
  a_mode0_osc: assert property (p_mode0_osc) else $error("mode 0 supply or oscillators wrong");

  property p_mode1;
    state == pms_pkg::ST_SLEEP && cur_mode == pms_pkg::LIGHT_SLEEP_MODE |-> core_reg_on_o
      && !fast_rc_oscillator_en_o && !crystal_oscillator_en_o
      && (slow_rc_oscillator_en_o ^ slow_crystal_oscillator_en_o);
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 supply or oscillators wrong");

  property p_mode2;
    state == pms_pkg::ST_SLEEP && cur_mode == pms_pkg::DEEP_SLEEP_MODE |-> !core_reg_on_o
      && !fast_rc_oscillator_en_o && !crystal_oscillator_en_o
      && (slow_rc_oscillator_en_o ^ slow_crystal_oscillator_en_o) && !volatile_ram_pwr_o;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 supply or oscillators wrong");

  property p_mode3;
    state == pms_pkg::ST_SLEEP && cur_mode == pms_pkg::SHUTDOWN_SLEEP_MODE |-> !core_reg_on_o
      && !fast_rc_oscillator_en_o && !crystal_oscillator_en_o && !slow_rc_oscillator_en_o
      && !slow_crystal_oscillator_en_o && retained_ram_pwr_o;
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 3 left something running");

  property p_timer_wake;
    state == pms_pkg::ST_SLEEP && cur_mode != pms_pkg::SHUTDOWN_SLEEP_MODE && st_exp
      |=> state != pms_pkg::ST_SLEEP ##[1:400] state == pms_pkg::ST_ACTIVE;
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("timer expiry did not wake");

  property p_mode3_frozen;
    state == pms_pkg::ST_SLEEP && cur_mode == pms_pkg::SHUTDOWN_SLEEP_MODE ##1
      state == pms_pkg::ST_SLEEP |-> $stable(st_cnt);
  endproperty
  a_mode3_frozen: assert property (p_mode3_frozen) else $error("timer ran in mode 3");

  property p_irq_wake;
    state == pms_pkg::ST_SLEEP && irq_pending_i |=> state inside {pms_pkg::ST_REGUP, pms_pkg::ST_OSCUP};
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("pending interrupt did not wake");

  property p_order;
    ($rose(fast_rc_oscillator_en_o || crystal_oscillator_en_o) |-> $past(core_reg_on_o))
      and ($fell(core_reg_on_o) |-> $past(!core_clk_en_o));
  endproperty
  a_order: assert property (p_order) else $error("supply and clock order broken");

  property p_wdog;
    wd_fire |-> sys_reset_o ##1 !wd_en && sys_reset_o;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog timeout gave no reset");

endmodule

/* File: bench/pms_wake_src.sv */
// Purpose: external reset and interrupt wake sources
// Assumes: bench asks for one pulse at a time
// Notes: reset pin rests high on its pull-up
`timescale 1ns/1ps
module pms_wake_src (
  input  wire logic clk_i,
  input  wire logic irq_req_i,
  input  wire logic pend_req_i,
  input  wire logic rst_req_i,
  output logic      ext_irq_o,
  output logic      irq_pending_o,
  output logic      ext_reset_n_o
);
  logic [2:0] cnt = 3'h0;
  logic [1:0] kind = 2'h0;
  // stretch a request over four cycles so the pin synchroniser sees it
  always_ff @(posedge clk_i) begin
    if (irq_req_i || pend_req_i || rst_req_i) begin
      cnt <= 3'h4;
      kind <= {rst_req_i, pend_req_i};
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign ext_irq_o = (cnt != 3'h0) && kind == 2'h0;
  assign irq_pending_o = (cnt != 3'h0) && kind == 2'h1;
  assign ext_reset_n_o = !((cnt != 3'h0) && kind == 2'h2); // pull-up level outside a pulse
endmodule

/* File: bench/testbench.sv */
// Purpose: bench for the power mode sequencer
// Assumes: watchdog count shortened to 4 slow ticks
// Notes: read data is checked from a queue
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, ireq = 0, preq = 0, rreq = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, wb_dat_o, d;
  logic        ack, irq_o, sys_reset_o, eirq, pend, rstn, ron, cen, frc, xo, src, sxo, rram, vram;
  logic [1:0]  pm;
  logic [31:0] rd_q[$];
  int          n_fail = 0, n_tests = 0, seed = 32'hCBFC;
  always #5 clk_i = ~clk_i;
  pms_wake_src pms_wake_src_inst (.clk_i(clk_i), .irq_req_i(ireq), .pend_req_i(preq), .rst_req_i(rreq),
    .ext_irq_o(eirq),
    .irq_pending_o(pend), .ext_reset_n_o(rstn));
  pms_top #(.WDOG_TICKS(4)) pms_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
    .ext_reset_n_i(rstn), .ext_irq_i(eirq), .irq_pending_i(pend), .irq_o(irq_o), .sys_reset_o(sys_reset_o),
    .power_mode_o(pm), .core_reg_on_o(ron), .core_clk_en_o(cen), .fast_rc_oscillator_en_o(frc),
    .crystal_oscillator_en_o(xo), .slow_rc_oscillator_en_o(src), .slow_crystal_oscillator_en_o(sxo),
    .retained_ram_pwr_o(rram), .volatile_ram_pwr_o(vram));
  // -----------------------------------------------------------
  // checking and bus tasks
  // -----------------------------------------------------------
  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // hold the request until ack is sampled, then idle one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t bus timed out", $time);
      wrap_up();
    end
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // bounded wait for active mode (s 0) or for the system reset (s 1)
  task automatic wfor(input int s, input int b);
    int k;
    k = 0;
    while ((s == 0 ? pm !== 2'h0 : sys_reset_o !== 1'b1) && k < b) begin
      @(posedge clk_i);
      k++;
    end
    n_tests++;
    if (s == 0 ? pm !== 2'h0 : sys_reset_o !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic sleep(input logic [31:0] m);
    bus(1'b1, pms_pkg::ADR_CTRL, m);
    bus(1'b1, pms_pkg::ADR_CMD, 32'h1);
    repeat (12) @(posedge clk_i);
  endtask
  // take the oldest expected read value when a read is answered
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) chk(wb_dat_o, rd_q.pop_front());
  end
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({pm, ron, cen, frc, xo}, {pms_pkg::ACTIVE_POWER_MODE, 4'hF});
    rd(8'h3C, 32'h0);
    rd(pms_pkg::ADR_ST_CMP, 32'(pms_pkg::CMP_RST));
    sleep(32'h15);
    chk({pm, ron, cen, frc, xo, src, sxo}, {pms_pkg::LIGHT_SLEEP_MODE, 6'h21});
    ireq <= 1'b1;
    @(posedge clk_i);
    ireq <= 1'b0;
    wfor(0, 400);
    chk({frc, xo, src, sxo}, 4'h5);
    rd(pms_pkg::ADR_IRQ_STAT, 32'h2);
    bus(1'b1, pms_pkg::ADR_IRQ_MASK, 32'h2);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    bus(1'b1, pms_pkg::ADR_IRQ_STAT, 32'h2);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    d = $random(seed) & 32'hFFFFFF;
    bus(1'b1, pms_pkg::ADR_ST_CMP, d);
    rd(pms_pkg::ADR_ST_CMP, d);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, pms_pkg::ADR_ST_CFG, i);
      rd(pms_pkg::ADR_ST_CFG, i);
    end
    bus(1'b1, pms_pkg::ADR_ST_CFG, 32'h0);
    bus(1'b1, pms_pkg::ADR_ST_CMP, 32'h2);
    sleep(32'h2);
    chk({pm, ron, frc, xo, src, rram, vram}, {pms_pkg::DEEP_SLEEP_MODE, 6'h06});
    wfor(0, 12000);
    sleep(32'h3);
    chk({pm, ron, src, sxo, frc, xo}, {pms_pkg::SHUTDOWN_SLEEP_MODE, 5'h00});
    repeat (10000) @(posedge clk_i);
    chk(pm, pms_pkg::SHUTDOWN_SLEEP_MODE);
    preq <= 1'b1;
    @(posedge clk_i);
    preq <= 1'b0;
    wfor(0, 400);
    sleep(32'h3);
    rreq <= 1'b1;
    @(posedge clk_i);
    rreq <= 1'b0;
    wfor(1, 20);
    wfor(0, 400);
    rd(pms_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, pms_pkg::ADR_CTRL, 32'h3);
    bus(1'b1, pms_pkg::ADR_WDOG, 32'h1);
    // clearing every two slow periods keeps a four-period watchdog quiet
    repeat (3) begin
      repeat (6000) @(posedge clk_i);
      bus(1'b1, pms_pkg::ADR_WDOG, 32'h2);
    end
    rd(pms_pkg::ADR_CTRL, 32'h3);
    wfor(1, 20000);
    rd(pms_pkg::ADR_CTRL, 32'h0);
    wrap_up();
  end
endmodule
